/* common/pwm_pkg.sv */
package pwm_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int NUM_CH = 6;
   localparam int NUM_PAIR = 3;
   localparam int DIV_W = 6;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] CMP_RST = 16'hFFFF;
   localparam logic HALT_RST = 1'b1;
   localparam logic [5:0] DIV_RST = 6'h00;

   // ----------------------------------------------------------------
   // Clock source and output actions
   // ----------------------------------------------------------------
   localparam logic [2:0] PS_EXT_PIN = 3'h7;

   typedef enum logic [1:0] {
      ELS_OFF = 2'b00,
      ELS_TOGGLE = 2'b01,
      ELS_CLEAR = 2'b10,
      ELS_SET = 2'b11
   } els_t;

endpackage

/* common/tick_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Timer clock enable between counter logic and the prescaler
interface tick_if;
   logic clear;
   logic halt;
   logic [2:0] sel;
   logic tick;

   modport prescaler (input clear, input halt, input sel, output tick);
   modport timer (output clear, output halt, output sel, input tick);
endinterface

`default_nettype wire

/* hw/timer_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_prescaler
   import pwm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_ext_clk_pin,
   tick_if.prescaler tk
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic sync3;
      logic [DIV_W-1:0] div;
      logic tick;
   } pre_state_t;

   pre_state_t state_reg;
   pre_state_t state_next;

   function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
      div_mask = DIV_W'((7'h01 << sel) - 7'h01);
   endfunction

   assign tk.tick = state_reg.tick;

   // ----------------------------------------------------------------
   // Divider and external edge detect
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      state_next.sync1 = i_ext_clk_pin;
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      if (tk.clear)
      begin
         state_next.div = DIV_RST;
         state_next.tick = 1'b0;
      end
      else if (tk.halt)
      begin
         state_next.tick = 1'b0;
      end
      else
      begin
         state_next.div = DIV_W'(state_reg.div + 6'h01);
         if (tk.sel == PS_EXT_PIN)
         begin
            // Rising edge of the synchronised pin only
            state_next.tick = state_reg.sync2 & ~state_reg.sync3;
         end
         else
         begin
            state_next.tick = (state_reg.div & div_mask(tk.sel)) == div_mask(tk.sel);
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         state_reg <= '{sync1: 1'b0, sync2: 1'b0, sync3: 1'b0, div: DIV_RST, tick: 1'b0};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

endmodule // timer_prescaler

`default_nettype wire

/* hw/timer_pwm_channel_gen.sv */
// Contract
// - Pair 0/1 link: buffered output on chan0_pin
// - Partner write takes effect next period
// - Linked odd channel idle, pin released
// - Pairs 2/3 and 4/5 link alike
// - Unbuffered compare uses current value only
// - Late smaller value misses that compare
// - Link bit overrides single mode bit
// - No overflow toggle, clear action: 0% duty
// - Full duty plus overflow toggle: 100% with clear action, 0% with set
// - Overflow toggles pin; compare ends pulse
// - Counter clear zeros counter and prescaler
// - Halt holds counter; reset sets halt
// - Counter at limit: flag, restart zero
`timescale 1ns/1ps
`default_nettype none

module timer_pwm_channel_gen
   import pwm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_ext_clk_pin,
   input wire logic [2:0] i_prescale_sel,
   input wire logic i_halt_wr,
   input wire logic i_halt_data,
   input wire logic i_counter_clear,
   input wire logic i_period_wr,
   input wire logic [15:0] i_period_data,
   input wire logic [NUM_CH-1:0] i_compare_wr,
   input wire logic [15:0] i_compare_data,
   input wire logic [NUM_PAIR-1:0] i_link_mode_bit,
   input wire logic [NUM_CH-1:0] i_single_mode_bit,
   input wire logic [NUM_CH-1:0] i_overflow_toggle_bit,
   input wire logic [NUM_CH-1:0] i_edge_level_sel_hi,
   input wire logic [NUM_CH-1:0] i_edge_level_sel_lo,
   input wire logic [NUM_CH-1:0] i_full_duty_bit,
   input wire logic i_overflow_flag_clr,
   input wire logic [NUM_CH-1:0] i_compare_flag_clr,
   output logic o_counter_halt_bit,
   output logic [15:0] o_counter,
   output logic [15:0] o_period_limit,
   output logic o_overflow_flag,
   output logic [NUM_CH-1:0] o_compare_flag,
   output logic [NUM_PAIR-1:0] o_active_odd,
   output logic [NUM_CH-1:0] o_chan_pin,
   output logic [NUM_CH-1:0] o_chan_oe
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic halt;
      logic clear_pend;
      logic [15:0] cnt;
      logic [15:0] period;
      logic [NUM_CH-1:0][15:0] cmp;
      logic [NUM_PAIR-1:0] written_odd;
      logic [NUM_PAIR-1:0] act_odd;
      logic ovf_flag;
      logic [NUM_CH-1:0] cmp_flag;
      logic [NUM_CH-1:0] pin;
      logic [NUM_CH-1:0] oe;
   } gen_state_t;

   gen_state_t state_reg;
   gen_state_t state_next;

   tick_if tk ();

   // Output action applied at a compare event
   function automatic logic apply_action(input logic pin, input els_t els);
      case (els)
         ELS_TOGGLE: apply_action = ~pin;
         ELS_CLEAR: apply_action = 1'b0;
         ELS_SET: apply_action = 1'b1;
         default: apply_action = pin;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   assign tk.clear = state_reg.clear_pend;
   assign tk.halt = state_reg.halt;
   assign tk.sel = i_prescale_sel;

   timer_prescaler u_prescaler (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_ext_clk_pin(i_ext_clk_pin),
      .tk(tk)
   );

   // ----------------------------------------------------------------
   // Counter, pairing and channel outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      logic run;
      logic ovf_ev;
      logic linked;
      logic active;
      logic cmp_ev;
      logic [15:0] cmp_val;
      els_t els;
      int k;
      run = 1'b0;
      ovf_ev = 1'b0;
      linked = 1'b0;
      active = 1'b0;
      cmp_ev = 1'b0;
      cmp_val = CMP_RST;
      els = ELS_OFF;
      k = 0;
      state_next = state_reg;

      if (i_halt_wr)
      begin
         state_next.halt = i_halt_data;
      end
      if (i_period_wr)
      begin
         state_next.period = i_period_data;
      end
      // Clear is one-shot; it never reads back as set
      state_next.clear_pend = i_counter_clear;

      run = tk.tick & ~state_reg.halt & ~state_reg.clear_pend;
      ovf_ev = run & (state_reg.cnt == state_reg.period);
      if (state_reg.clear_pend)
      begin
         state_next.cnt = CNT_RST;
      end
      else if (ovf_ev)
      begin
         state_next.cnt = CNT_RST;
      end
      else if (run)
      begin
         state_next.cnt = 16'(state_reg.cnt + 16'h0001);
      end
      // Set wins over a clear in the same cycle
      state_next.ovf_flag = (state_reg.ovf_flag & ~i_overflow_flag_clr) | ovf_ev;

      // Channel registers are written in place: unbuffered by design
      for (int c = 0; c < NUM_CH; c++)
      begin
         if (i_compare_wr[c])
         begin
            state_next.cmp[c] = i_compare_data;
         end
      end

      // Pair bookkeeping: the last written set takes over at overflow
      for (int p = 0; p < NUM_PAIR; p++)
      begin
         if (!i_link_mode_bit[p])
         begin
            state_next.written_odd[p] = 1'b0;
            state_next.act_odd[p] = 1'b0;
         end
         else
         begin
            if (i_compare_wr[2*p+1])
            begin
               state_next.written_odd[p] = 1'b1;
            end
            else if (i_compare_wr[2*p])
            begin
               state_next.written_odd[p] = 1'b0;
            end
            if (ovf_ev)
            begin
               state_next.act_odd[p] = state_next.written_odd[p];
            end
         end
      end

      for (int c = 0; c < NUM_CH; c++)
      begin
         k = c / 2;
         linked = i_link_mode_bit[k];
         els = els_t'({i_edge_level_sel_hi[c], i_edge_level_sel_lo[c]});
         if ((c % 2 == 1) && linked)
         begin
            // Odd pin goes back to general-purpose use
            state_next.oe[c] = 1'b0;
            active = 1'b0;
         end
         else
         begin
            // Link bit wins over the single mode bit
            active = ((c % 2 == 0) && linked) || i_single_mode_bit[c];
            state_next.oe[c] = active && (els != ELS_OFF);
         end

         if ((c % 2 == 0) && linked && state_reg.act_odd[k])
         begin
            cmp_val = state_reg.cmp[c | 1];
         end
         else
         begin
            cmp_val = state_reg.cmp[c];
         end
         // Only an exact match counts; a value already passed waits a period
         cmp_ev = active && run && (state_reg.cnt == cmp_val);

         state_next.cmp_flag[c] = (state_reg.cmp_flag[c] & ~i_compare_flag_clr[c]) | cmp_ev;

         if (active)
         begin
            if (cmp_ev)
            begin
               state_next.pin[c] = apply_action(state_next.pin[c], els);
            end
            if (ovf_ev && i_overflow_toggle_bit[c])
            begin
               state_next.pin[c] = ~state_next.pin[c];
            end
            if (i_full_duty_bit[c] && i_overflow_toggle_bit[c])
            begin
               // Pulse level is the complement of the compare action
               state_next.pin[c] = ~els[0];
            end
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         state_reg.halt <= HALT_RST;
         state_reg.clear_pend <= 1'b0;
         state_reg.cnt <= CNT_RST;
         state_reg.period <= PERIOD_RST;
         state_reg.cmp <= {NUM_CH{CMP_RST}};
         state_reg.written_odd <= '0;
         state_reg.act_odd <= '0;
         state_reg.ovf_flag <= 1'b0;
         state_reg.cmp_flag <= '0;
         state_reg.pin <= '0;
         state_reg.oe <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_counter_halt_bit = state_reg.halt;
   assign o_counter = state_reg.cnt;
   assign o_period_limit = state_reg.period;
   assign o_overflow_flag = state_reg.ovf_flag;
   assign o_compare_flag = state_reg.cmp_flag;
   assign o_active_odd = state_reg.act_odd;
   assign o_chan_pin = state_reg.pin;
   assign o_chan_oe = state_reg.oe;

endmodule // timer_pwm_channel_gen

`default_nettype wire

/* verification/timer_pwm_channel_gen_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_pwm_channel_gen_checker
   import pwm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_halt_wr,
   input wire logic i_halt_data,
   input wire logic i_counter_clear,
   input wire logic i_period_wr,
   input wire logic [15:0] i_period_data,
   input wire logic [NUM_PAIR-1:0] i_link_mode_bit,
   input wire logic [NUM_CH-1:0] i_single_mode_bit,
   input wire logic [NUM_CH-1:0] i_overflow_toggle_bit,
   input wire logic [NUM_CH-1:0] i_edge_level_sel_lo,
   input wire logic [NUM_CH-1:0] i_full_duty_bit,
   input wire logic o_counter_halt_bit,
   input wire logic [15:0] o_counter,
   input wire logic [15:0] o_period_limit,
   input wire logic o_overflow_flag,
   input wire logic [NUM_CH-1:0] o_chan_pin,
   input wire logic [NUM_CH-1:0] o_chan_oe
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   property p_halt_load;
      i_halt_wr |=> o_counter_halt_bit == $past(i_halt_data);
   endproperty
   a_halt_load: assert property (p_halt_load) else $error("halt bit not loaded");

   // Two halted cycles: a tick already in flight has landed; a clear lands one cycle late
   property p_halt_hold;
      o_counter_halt_bit && $past(o_counter_halt_bit) && !i_counter_clear
         && !$past(i_counter_clear) |=> $stable(o_counter);
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("counter moved while halted");

   // Clear is registered first, so the counter is zero two edges after the pulse
   property p_clear;
      i_counter_clear |-> ##2 o_counter == 16'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("counter not cleared");

   property p_period;
      i_period_wr |=> o_period_limit == $past(i_period_data);
   endproperty
   a_period: assert property (p_period) else $error("period not loaded");

   property p_step;
      $changed(o_counter) |-> o_counter == 16'h0000 || o_counter == $past(o_counter) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("counter jumped");

   property p_wrap;
      $rose(o_overflow_flag) |-> o_counter == 16'h0000 && $past(o_counter) == $past(o_period_limit);
   endproperty
   a_wrap: assert property (p_wrap) else $error("overflow away from limit");

   property p_odd_off;
      ({o_chan_oe[5], o_chan_oe[3], o_chan_oe[1]} & i_link_mode_bit & $past(i_link_mode_bit)) == 3'h0;
   endproperty
   a_odd_off: assert property (p_odd_off) else $error("linked odd pin driven");

   property p_full;
      $past(i_full_duty_bit[0] && i_overflow_toggle_bit[0] && i_single_mode_bit[0])
         |-> o_chan_pin[0] == !$past(i_edge_level_sel_lo[0]);
   endproperty
   a_full: assert property (p_full) else $error("full duty level wrong");
endmodule // timer_pwm_channel_gen_checker

bind timer_pwm_channel_gen timer_pwm_channel_gen_checker u_timer_pwm_channel_gen_checker (.*);

`default_nettype wire

/* verification/timer_pwm_channel_gen_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_pwm_channel_gen_tb_top;
   import pwm_pkg::*;
   logic i_clk = 1'b0, i_reset_n = 1'b0, i_ext_clk_pin = 1'b0, i_halt_wr = 1'b0;
   logic i_halt_data = 1'b0, i_counter_clear = 1'b0, i_period_wr = 1'b0;
   logic i_overflow_flag_clr = 1'b0, o_counter_halt_bit, o_overflow_flag;
   logic [2:0] i_prescale_sel = 3'h0, i_link_mode_bit = 3'h0, o_active_odd;
   logic [15:0] i_period_data = 16'h0000, i_compare_data = 16'h0000, o_counter, o_period_limit;
   logic [5:0] i_compare_wr = 6'h00, i_single_mode_bit = 6'h00, i_overflow_toggle_bit = 6'h00;
   logic [5:0] i_edge_level_sel_hi = 6'h00, i_edge_level_sel_lo = 6'h00, i_full_duty_bit = 6'h00;
   logic [5:0] i_compare_flag_clr = 6'h00, o_compare_flag, o_chan_pin, o_chan_oe;
   int n_mismatch = 0, checked = 0, seed = 76, per, w, v, c;
   timer_pwm_channel_gen u_timer_pwm_channel_gen (.*);
   always #5 i_clk = ~i_clk;

   // ----
   // Helpers
   // ----
   task automatic check(input string nm, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [15:0] exp_ones(input int wd, lo, n);
      return 16'(n * (lo ? per - wd : wd + 1));
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic set_halt(input logic d);
      @(posedge i_clk);
      i_halt_wr <= 1'b1;
      i_halt_data <= d;
      @(posedge i_clk);
      i_halt_wr <= 1'b0;
      #1;
      check("halt", o_counter_halt_bit, d);
   endtask
   task automatic wr_cmp(input int ch, input int d);
      @(posedge i_clk);
      i_compare_wr <= 6'h01 << ch;
      i_compare_data <= d[15:0];
      @(posedge i_clk);
      i_compare_wr <= 6'h00;
      #1;
   endtask
   task automatic start;
      set_halt(1'b1);
      @(posedge i_clk);
      i_counter_clear <= 1'b1;
      i_period_wr <= 1'b1;
      i_period_data <= per[15:0];
      @(posedge i_clk);
      i_counter_clear <= 1'b0;
      i_period_wr <= 1'b0;
      // Counter is zeroed one edge after the clear is taken
      cyc(1);
      check("counter", o_counter, 16'h0000);
   endtask
   // Bounded: periods here never exceed 12 cycles; ends just after an overflow
   task automatic wait_wrap;
      for (int i = 0; i < 64 && o_counter !== per[15:0]; i++)
         cyc(1);
      cyc(1);
   endtask
   task automatic ones(input int ch, n);
      wait_wrap;
      c = 0;
      repeat (n * (per + 1))
      begin
         c += int'(o_chan_pin[ch]);
         cyc(1);
      end
   endtask

   // ----
   // Sequence
   // ----
   initial
   begin
      #200000;
      n_mismatch++;
      give_verdict;
   end
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      cyc(1);
      check("halt", o_counter_halt_bit, HALT_RST);
      check("oe", o_chan_oe, 16'h0000);
      per = 4 + ($random(seed) & 7);
      w = 1 + ($random(seed) & 32'h7FFF) % (per - 1);
      start;
      wr_cmp(0, w);
      i_single_mode_bit <= 6'h01;
      i_overflow_toggle_bit <= 6'h01;
      i_edge_level_sel_hi <= 6'h01;
      set_halt(1'b0);
      wait_wrap;
      check("ovf", o_overflow_flag, 1'b1);
      check("cflag", o_compare_flag, 6'h01);
      for (int lo = 0; lo < 2; lo++)
      begin
         i_edge_level_sel_lo[0] <= lo[0];
         wait_wrap;
         ones(0, 2);
         check("duty", c[15:0], exp_ones(w, lo, 2));
         i_full_duty_bit[0] <= 1'b1;
         ones(0, 1);
         check("full", c[15:0], lo ? 16'h0000 : 16'(per + 1));
         i_full_duty_bit[0] <= 1'b0;
      end
      i_edge_level_sel_lo <= 6'h00;
      i_overflow_toggle_bit <= 6'h00;
      wait_wrap;
      ones(0, 2);
      check("zero", c[15:0], 16'h0000);
      i_overflow_toggle_bit <= 6'h01;
      wr_cmp(0, per - 1);
      wait_wrap;
      wait_wrap;
      cyc(1);
      // New value lands after the counter has passed it
      wr_cmp(0, 0);
      ones(0, 1);
      check("missed", c[15:0], 16'h0000);
      ones(0, 1);
      check("recover", c[15:0], exp_ones(0, 0, 1));
      // Wider value written right after an overflow: no compare lost
      wr_cmp(0, per - 1);
      ones(0, 1);
      check("longer", c[15:0], exp_ones(per - 1, 0, 1));
      // Narrower value written after its compare, landing by the overflow
      for (int i = 0; i < 64 && o_counter !== per[15:0]; i++)
         cyc(1);
      i_compare_wr <= 6'h01;
      i_compare_data <= 16'h0000;
      cyc(1);
      i_compare_wr <= 6'h00;
      ones(0, 1);
      check("shorter", c[15:0], exp_ones(0, 0, 1));
      for (int p = 0; p < 3; p++)
      begin
         start;
         i_single_mode_bit <= 6'(($random(seed) & 1) << 2 * p);
         i_link_mode_bit <= 3'h1 << p;
         i_overflow_toggle_bit <= 6'h01 << 2 * p;
         i_edge_level_sel_hi <= 6'h01 << 2 * p;
         wr_cmp(2 * p, w);
         set_halt(1'b0);
         ones(2 * p, 1);
         check("even", c[15:0], exp_ones(w, 0, 1));
         check("oe", {14'h0000, o_chan_oe[2 * p + 1], o_chan_oe[2 * p]}, 16'h0001);
         v = per - w;
         wr_cmp(2 * p + 1, v);
         ones(2 * p, 1);
         check("odd", c[15:0], exp_ones(v, 0, 1));
         check("act", o_active_odd[p], 1'b1);
         wr_cmp(2 * p, w);
         ones(2 * p, 1);
         check("back", c[15:0], exp_ones(w, 0, 1));
         check("act", o_active_odd[p], 1'b0);
      end
      set_halt(1'b1);
      @(posedge i_clk);
      i_overflow_flag_clr <= 1'b1;
      i_compare_flag_clr <= 6'h3F;
      v = int'(o_counter);
      @(posedge i_clk);
      i_overflow_flag_clr <= 1'b0;
      i_compare_flag_clr <= 6'h00;
      cyc(5);
      check("flags", {o_overflow_flag, o_compare_flag}, 16'h0000);
      check("held", o_counter, v[15:0]);
      give_verdict;
   end
endmodule // timer_pwm_channel_gen_tb_top

`default_nettype wire
